// ### bench/mcf_mem_model.sv
// Far-side memory model: counts the beats of each access
`default_nettype none
module mcf_mem_model (
	// Clock and strobes
	input wire logic       sys_clk,
	input wire logic       clr,
	input wire logic       beat,
	// Beats since last clear
	output var logic [7:0] beats
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge sys_clk) begin
		if (clr)
			beats <= 8'h00;
		else if (beat)
			beats <= beats + 8'h01;
	end
endmodule
`default_nettype wire

// ### bench/mcf_properties.sv
// Port checker of the memory config block
`default_nettype none
module mcf_properties (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	// Bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Decoded outputs
	input wire logic [12:0] col_addr_q,
	input wire logic        col_map_bad_q,
	input wire logic [1:0]  bank_is_sdram_q,
	input wire logic [3:0]  bank_width_q,
	// Access timer
	input wire logic        acc_start,
	input wire logic        acc_write,
	input wire logic        acc_busy_q,
	input wire logic        acc_beat_q,
	input wire logic        acc_done_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       wr_q;
	logic [2:0] nb_q;
	// The clock enable is high at every start, so one is taken when idle
	always @(posedge sys_clk) begin
		if (acc_start && !acc_busy_q) begin
			wr_q <= acc_write;
			nb_q <= 3'h0;
		end else if (acc_beat_q && !acc_done_q) begin
			nb_q <= nb_q + 3'h1;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_resp_time: assert property (s_wr_both |-> ##[2:3] s_axi_bvalid)
		else $error("write response late");
	a_read_data_time: assert property (s_rd_take |-> ##[1:2] s_axi_rvalid)
		else $error("read data late");
	a_bvalid_holds: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	a_rvalid_holds: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("rvalid dropped early");
	a_done_ends_busy: assert property (
		acc_done_q |-> acc_beat_q && !acc_busy_q)
		else $error("done without last beat");
	a_write_one_beat: assert property (acc_beat_q && wr_q |-> acc_done_q)
		else $error("write took several beats");
	a_burst_four: assert property (
		acc_done_q && !wr_q |-> nb_q == 3'h0 || nb_q == 3'h3)
		else $error("read beat count wrong");
	a_col_reserved: assert property (
		col_map_bad_q |-> col_addr_q == 13'h0000)
		else $error("reserved column code drove bits");
	a_sdram_width: assert property (
		bank_is_sdram_q[0] |-> bank_width_q[1:0] != 2'h2)
		else $error("sdram bank 0 wide");
	a_sdram1_width: assert property (
		bank_is_sdram_q[1] |-> bank_width_q[3:2] != 2'h2)
		else $error("sdram bank 1 wide");
endmodule

bind mcf_top mcf_properties u_props (
	.sys_clk(sys_clk), .sys_rst(sys_rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.col_addr_q(col_addr_q), .col_map_bad_q(col_map_bad_q),
	.bank_is_sdram_q(bank_is_sdram_q), .bank_width_q(bank_width_q),
	.acc_start(acc_start), .acc_write(acc_write), .acc_busy_q(acc_busy_q),
	.acc_beat_q(acc_beat_q), .acc_done_q(acc_done_q)
);
`default_nettype wire

// ### bench/mcf_top_tb_top.sv
// Self-checking bench of the memory config block
`include "mcf_consts.vh"
`default_nettype none
module mcf_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk = 1'b0, sys_rst = 1'b1, sys_ce = 1'b1;
	logic        boot_width_strap = 1'b0, mem_bank = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, beats;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, lf = 32'h00000033;
	logic [3:0]  s_axi_wstrb = 4'hF, bank_width_q, gen_port_w32_q;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_rready = 1'b0, acc_start = 1'b0, acc_write = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, col_map_bad_q, acc_busy_q;
	logic        acc_beat_q, acc_done_q;
	logic [1:0]  s_axi_bresp, s_axi_rresp, bank_is_sdram_q;
	logic [24:0] mem_addr = 25'h0;
	logic [12:0] row_addr_q, col_addr_q;
	logic [2:0]  acc_sel = 3'h0;
	int          bad_count = 0, n_compared = 0;

	mcf_top u_mcf_top (.*);
	mcf_mem_model u_mcf_mem_model (.sys_clk(sys_clk), .clr(acc_start),
		.beat(acc_beat_q), .beats(beats));

	initial forever #2 sys_clk = ~sys_clk;

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [1:0] lw(input logic [1:0] c);
		return c == 2'h2 ? `MCF_W8 : c == 2'h1 ? `MCF_W32 : `MCF_W16;
	endfunction
	function automatic logic [12:0] row_e(input logic [1:0] c, logic [24:0] a);
		case (c)
			2'h0: return {3'h0, a[18], a[17:9]};
			2'h1: return {a[22], a[18], a[20], a[19], a[17:9]};
			2'h2: return {a[20], a[22], a[21], a[19], a[17:9]};
			default: return {a[22], a[23], a[21], a[19], a[17:9]};
		endcase
	endfunction
	function automatic logic [12:0] col_e(input logic [3:0] c, logic [24:0] a);
		case (c)
			4'h0: return {2'h0, a[22], a[20], a[18], a[8:1]};
			4'h1: return {4'h0, a[19], a[18], a[8:2]};
			4'h9: return {3'h0, a[24], a[23], a[21], a[8:2]};
			default: return 13'h0000;
		endcase
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, ex);
		n_compared++;
		if (seen !== ex) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, ex, seen);
		end
	endtask
	task automatic finish_test;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, logic [31:0] d, output logic [1:0] r);
		int n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 99);
		if (s_axi_bvalid !== 1'b1) bad_count++;
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, logic [1:0] r);
		int n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 99);
		if (s_axi_rvalid !== 1'b1) bad_count++;
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge sys_clk);
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		finish_test;
	end

	initial begin
		logic [1:0]  r;
		logic [31:0] d, w, pg;
		logic [3:0]  f, b, cc;
		logic [7:0]  ta;
		int          n;
		boot_width_strap = lf[4];
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(`MCF_OFS_LAYOUT, d, r);
		chk("strap", d[0], boot_width_strap);
		chk("w32_0", gen_port_w32_q[0], boot_width_strap);
		rd(`MCF_OFS_GEN_TIME, d, r);
		chk("gen_rst", d, `MCF_RST_GEN_TIME);
		s_axi_wstrb <= 4'h3;
		wr(`MCF_OFS_AUX_TIME, 32'hFFFFFFFF, r);
		s_axi_wstrb <= 4'hF;
		rd(`MCF_OFS_AUX_TIME, d, r);
		chk("strobe", d, (`MCF_RST_AUX_TIME & 32'hFFFF0000) | 32'h0000FFFF);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			lf = nxt(lf);
			cc = i == 0 ? 4'h0 : i == 1 ? 4'h1 : i == 2 ? 4'h9 : 4'hF;
			w = {12'h000, 2'(3 - i), 2'(i), 2'(3 - i), 2'(i), cc, cc, lf[3:0]};
			wr(`MCF_OFS_LAYOUT, w, r);
			rd(`MCF_OFS_LAYOUT, d, r);
			chk("layout", d, w);
			chk("sdram", bank_is_sdram_q, {w[19], w[17]});
			chk("width", bank_width_q, {lw(w[19:18]), lw(w[17:16])});
			chk("w32", gen_port_w32_q, w[3:0]);
			for (int k = 0; k < 2; k++) begin
				mem_bank <= k[0];
				mem_addr <= lf[31:7];
				repeat (2) @(posedge sys_clk);
				chk("row", row_addr_q, row_e(w[13 + 2 * k -: 2], lf[31:7]));
				chk("col", col_addr_q, col_e(cc, lf[31:7]));
				chk("col_bad", col_map_bad_q, cc > 4'h9);
				lf = nxt(lf);
			end
		end
		rd(8'h14, d, r);
		chk("rd_resp", r, `MCF_RESP_SLVERR);
		chk("rd_data", d, 32'h0);
		wr(8'h1C, 32'hFFFFFFFF, r);
		chk("wr_resp", r, `MCF_RESP_SLVERR);
		d = 32'(row_addr_q);
		sys_ce <= 1'b0;
		mem_addr <= ~mem_addr;
		repeat (3) @(posedge sys_clk);
		chk("ce_hold", row_addr_q, d);
		sys_ce <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk("ce_run", row_addr_q, row_e(w[15:14], mem_addr));
		$display("test maps done");
		for (int s = 0; s < 8; s++) begin
			for (int m = 0; m < 3; m++) begin
				lf = nxt(lf);
				f = lf[3:0] == 4'h0 ? 4'h1 : lf[3:0];
				b = m == 2 ? f : lf[7:4] < 4'h2 ? 4'h2 : lf[7:4];
				pg = m == 2 ? 32'h0 : 32'h1 << (s < 4 ? 12 + s : 4 + s);
				ta = s < 4 ? `MCF_OFS_AUX_TIME : `MCF_OFS_GEN_TIME;
				wr(ta, {4{f, b}}, r);
				rd(ta, d, r);
				chk("timing", d, {4{f, b}});
				wr(`MCF_OFS_PAGE, pg, r);
				acc_sel <= 3'(s);
				acc_write <= m == 0;
				acc_start <= 1'b1;
				@(posedge sys_clk);
				acc_start <= 1'b0;
				n = 0;
				do begin
					@(posedge sys_clk);
					n++;
				end while (acc_done_q !== 1'b1 && n < 300);
				if (acc_done_q !== 1'b1) bad_count++;
				@(posedge sys_clk);
				chk("cycles", n, f + 2 + (m == 1 ? 3 * (b + 1) : 0));
				chk("beats", beats, m == 1 ? 4 : 1);
				chk("busy", acc_busy_q, 1'b0);
			end
		end
		$display("test timer done");
		boot_width_strap <= ~boot_width_strap;
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(`MCF_OFS_LAYOUT, d, r);
		chk("strap2", d[0], boot_width_strap);
		chk("w32_2", gen_port_w32_q[0], boot_width_strap);
		rd(`MCF_OFS_AUX_TIME, d, r);
		chk("aux_rst", d, `MCF_RST_AUX_TIME);
		$display("test reset again done");
		finish_test;
	end
endmodule
`default_nettype wire

// ### hw/mcf_top.v
// Memory configuration register bank with address maps and access timer
//
// Operation
// - bank1 layout codes: SDRAM16, SDRAM8, DRAM32, DRAM16
// - bank0 layout uses the same encoding
// - row map selects processor address bits
// - ten column map codes; others reserved
// - width bit set means 32-bit, else 16
// - select 0 width loaded from strap
// - page read: first field, then three burst
// - writes always timed by first field
// - general timing register holds eight nibbles
// - per-select read page enable bits
`include "mcf_consts.vh"
`default_nettype none

module mcf_top (
	// Clock, reset, enable
	input  wire        sys_clk,
	input  wire        sys_rst,
	input  wire        sys_ce,
	// Strap
	input  wire        boot_width_strap,
	// AXI4-Lite write address
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Address multiplexer
	input  wire [24:0] mem_addr,
	input  wire        mem_bank,
	output reg  [12:0] row_addr_q,
	output reg  [12:0] col_addr_q,
	output reg         col_map_bad_q,
	// Decoded bank and port configuration
	output reg  [1:0]  bank_is_sdram_q,
	output reg  [3:0]  bank_width_q,
	output reg  [3:0]  gen_port_w32_q,
	// Access timer: sel 0-3 auxiliary, 4-7 general
	input  wire        acc_start,
	input  wire [2:0]  acc_sel,
	input  wire        acc_write,
	output reg         acc_busy_q,
	output reg         acc_beat_q,
	output reg         acc_done_q
);
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN  = 1'b1;

	// ------------------------------------------------------------------
	// Decode functions
	// ------------------------------------------------------------------
	function [12:0] row_map;
		input [1:0]  sel;
		input [24:0] a;
		begin
			case (sel)
			2'h0: row_map = {3'h0, a[18], a[17:9]};
			2'h1: row_map = {a[22], a[18], a[20], a[19], a[17:9]};
			2'h2: row_map = {a[20], a[22], a[21], a[19], a[17:9]};
			default: row_map = {a[22], a[23], a[21], a[19], a[17:9]};
			endcase
		end
	endfunction
	// Undefined positions in the column maps are driven low
	function [12:0] col_map;
		input [3:0]  sel;
		input [24:0] a;
		begin
			case (sel)
			4'h0: col_map = {2'h0, a[22], a[20], a[18], a[8:1]};
			4'h1: col_map = {4'h0, a[19], a[18], a[8:2]};
			4'h2: col_map = {3'h0, a[21], a[20], a[18], a[8:2]};
			4'h3: col_map = {2'h0, a[23], a[22], a[20], a[18], a[8:2]};
			4'h4: col_map = {2'h0, a[24], a[22], a[20], a[18], a[8:2]};
			4'h5: col_map = {1'h0, a[18], 2'h0, a[8:0]};
			4'h6: col_map = {a[22], 2'h0, a[21], a[8:0]};
			4'h7: col_map = {1'h0, a[18], 2'h0, a[21], a[8:1]};
			4'h8: col_map = {a[22], 2'h0, a[23], a[21], a[8:1]};
			4'h9: col_map = {3'h0, a[24], a[23], a[21], a[8:2]};
			default: col_map = 13'h0000;
			endcase
		end
	endfunction
	// Nibble of a timing register: select s, first at 8s+4, burst at 8s
	function [3:0] acc_time;
		input [31:0] aux;
		input [31:0] gen;
		input [2:0]  sel;
		input        burst;
		reg   [4:0]  base;
		begin
			base = {sel[1:0], ~burst, 2'b00};
			acc_time = sel[2] ? gen[base +: 4] : aux[base +: 4];
		end
	endfunction
	function decode_hit;
		input [7:0] addr;
		begin
			decode_hit = ({addr[7:2], 2'b00} <= `MCF_OFS_STATUS);
		end
	endfunction

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	reg  [31:0] layout_q;
	reg  [31:0] aux_select_timing_q;
	reg  [31:0] chip_select_timing_q;
	reg  [31:0] page_q;
	reg  [7:0]  wr_addr_q;
	reg         aw_held_q;
	reg  [31:0] wr_data_q;
	reg  [3:0]  wr_strb_q;
	reg         w_held_q;
	reg         state_q;
	reg  [2:0]  sel_q;
	reg  [3:0]  cnt_q;
	reg  [1:0]  beats_left_q;
	wire [31:0] strb_mask = {{8{wr_strb_q[3]}}, {8{wr_strb_q[2]}},
		{8{wr_strb_q[1]}}, {8{wr_strb_q[0]}}};
	wire        do_write = aw_held_q && w_held_q && !s_axi_bvalid;
	wire [7:0]  wr_word = {wr_addr_q[7:2], 2'b00};
	wire [31:0] status = {22'h0, cnt_q, beats_left_q, sel_q, acc_busy_q};
	wire [7:0]  page_on = page_q[`MCF_F_GEN_PAGE +: 8];
	wire [7:0]  page_sel = {page_on[3:0], page_on[7:4]};
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [31:0] m;
		begin
			merge = (old & ~m) | (nw & m);
		end
	endfunction

	// ------------------------------------------------------------------
	// AXI4-Lite write path
	// ------------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `MCF_RESP_OKAY;
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			wr_addr_q <= 8'h00;
			wr_data_q <= 32'h00000000;
			wr_strb_q <= 4'h0;
			layout_q <= `MCF_RST_LAYOUT;
			layout_q[`MCF_F_GEN_WIDTH] <= boot_width_strap;
			aux_select_timing_q <= `MCF_RST_AUX_TIME;
			chip_select_timing_q <= `MCF_RST_GEN_TIME;
			page_q <= `MCF_RST_PAGE;
		end else if (sys_ce) begin
			s_axi_awready <= !aw_held_q && !s_axi_bvalid &&
				!(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_held_q && !s_axi_bvalid &&
				!(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				wr_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wr_data_q <= s_axi_wdata;
				wr_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= decode_hit(wr_addr_q) ? `MCF_RESP_OKAY : `MCF_RESP_SLVERR;
				case (wr_word)
				`MCF_OFS_LAYOUT: layout_q <= merge(layout_q, wr_data_q,
					strb_mask & `MCF_LAYOUT_MASK);
				`MCF_OFS_AUX_TIME: aux_select_timing_q <= merge(
					aux_select_timing_q, wr_data_q, strb_mask);
				`MCF_OFS_GEN_TIME: chip_select_timing_q <= merge(
					chip_select_timing_q, wr_data_q, strb_mask);
				`MCF_OFS_PAGE: page_q <= merge(page_q, wr_data_q,
					strb_mask & `MCF_PAGE_MASK);
				default: page_q <= page_q;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// ------------------------------------------------------------------
	// AXI4-Lite read path
	// ------------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `MCF_RESP_OKAY;
		end else if (sys_ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= decode_hit(s_axi_araddr) ?
					`MCF_RESP_OKAY : `MCF_RESP_SLVERR;
				case ({s_axi_araddr[7:2], 2'b00})
				`MCF_OFS_LAYOUT:   s_axi_rdata <= layout_q;
				`MCF_OFS_AUX_TIME: s_axi_rdata <= aux_select_timing_q;
				`MCF_OFS_GEN_TIME: s_axi_rdata <= chip_select_timing_q;
				`MCF_OFS_PAGE:     s_axi_rdata <= page_q;
				`MCF_OFS_STATUS:   s_axi_rdata <= status;
				default:           s_axi_rdata <= 32'h00000000;
				endcase
			end else if (!s_axi_rvalid || s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
	// ------------------------------------------------------------------
	// Bank decode, one copy per bank
	// ------------------------------------------------------------------
	genvar b;
	generate
		for (b = 0; b < 2; b = b + 1) begin : g_bank
			wire [1:0] lay = layout_q[`MCF_F_BANK0_LAY + 2*b +: 2];
			always @(posedge sys_clk) begin
				if (sys_rst) begin
					bank_is_sdram_q[b] <= 1'b0;
					bank_width_q[2*b +: 2] <= `MCF_W16;
				end else if (sys_ce) begin
					bank_is_sdram_q[b] <= lay[1];
					case (lay)
					`MCF_LAY_SDRAM16: bank_width_q[2*b +: 2] <= `MCF_W16;
					`MCF_LAY_SDRAM8:  bank_width_q[2*b +: 2] <= `MCF_W8;
					`MCF_LAY_DRAM32:  bank_width_q[2*b +: 2] <= `MCF_W32;
					default:          bank_width_q[2*b +: 2] <= `MCF_W16;
					endcase
				end
			end
		end
	endgenerate
	// ------------------------------------------------------------------
	// Row and column multiplexer and port widths
	// ------------------------------------------------------------------
	wire [1:0] row_sel = mem_bank ? layout_q[`MCF_F_BANK1_ROW +: 2] :
		layout_q[`MCF_F_BANK0_ROW +: 2];
	wire [3:0] col_sel = mem_bank ? layout_q[`MCF_F_BANK1_COL +: 4] :
		layout_q[`MCF_F_BANK0_COL +: 4];
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			row_addr_q <= 13'h0000;
			col_addr_q <= 13'h0000;
			col_map_bad_q <= 1'b0;
			gen_port_w32_q <= 4'h0;
		end else if (sys_ce) begin
			row_addr_q <= row_map(row_sel, mem_addr);
			col_addr_q <= col_map(col_sel, mem_addr);
			// Reserved codes give a zero column and raise a flag
			col_map_bad_q <= (col_sel > `MCF_COL_LAST);
			gen_port_w32_q <= layout_q[`MCF_F_GEN_WIDTH +: 4];
		end
	end
	// ------------------------------------------------------------------
	// Access timer
	// ------------------------------------------------------------------
	// Fields are read live; software should not retime a busy select.
	// Software keeps fields equal without page mode, and >= 1 / >= 2
	// with it; a zero burst field would shorten the page beats.
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			sel_q <= 3'h0;
			cnt_q <= 4'h0;
			beats_left_q <= 2'h0;
			acc_busy_q <= 1'b0;
			acc_beat_q <= 1'b0;
			acc_done_q <= 1'b0;
		end else if (sys_ce) begin
			acc_beat_q <= 1'b0;
			acc_done_q <= 1'b0;
			case (state_q)
			ST_IDLE: begin
				if (acc_start) begin
					state_q <= ST_RUN;
					acc_busy_q <= 1'b1;
					sel_q <= acc_sel;
					cnt_q <= acc_time(aux_select_timing_q,
						chip_select_timing_q, acc_sel, 1'b0);
					beats_left_q <= (!acc_write && page_sel[acc_sel]) ?
						`MCF_BURST_NEXT : 2'h0;
				end
			end
			ST_RUN: begin
				if (cnt_q == 4'h0) begin
					acc_beat_q <= 1'b1;
					if (beats_left_q == 2'h0) begin
						state_q <= ST_IDLE;
						acc_busy_q <= 1'b0;
						acc_done_q <= 1'b1;
					end else begin
						beats_left_q <= beats_left_q - 2'h1;
						cnt_q <= acc_time(aux_select_timing_q,
							chip_select_timing_q, sel_q, 1'b1);
					end
				end else begin
					cnt_q <= cnt_q - 4'h1;
				end
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### inc/mcf_consts.vh
// Register map, field layout, reset values and codes of the memory config block
`ifndef MCF_CONSTS_VH
`define MCF_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MCF_OFS_LAYOUT     8'h00
`define MCF_OFS_AUX_TIME   8'h04
`define MCF_OFS_GEN_TIME   8'h08
`define MCF_OFS_PAGE       8'h0C
`define MCF_OFS_STATUS     8'h10

// ----------------------------------------------------------------------
// Layout register fields (LSB positions)
// ----------------------------------------------------------------------
`define MCF_F_GEN_WIDTH    0
`define MCF_F_BANK0_COL    4
`define MCF_F_BANK1_COL    8
`define MCF_F_BANK0_ROW    12
`define MCF_F_BANK1_ROW    14
`define MCF_F_BANK0_LAY    16
`define MCF_F_BANK1_LAY    18
`define MCF_LAYOUT_MASK    32'h000FFFFF

// ----------------------------------------------------------------------
// Read page enable register fields
// ----------------------------------------------------------------------
`define MCF_F_GEN_PAGE     8
`define MCF_F_AUX_PAGE     12
`define MCF_PAGE_MASK      32'h0000FF00

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MCF_RST_LAYOUT     32'h00000000
`define MCF_RST_AUX_TIME   32'h00000000
`define MCF_RST_GEN_TIME   32'h000000FF
`define MCF_RST_PAGE       32'h00000000

// ----------------------------------------------------------------------
// Bank layout codes and width codes
// ----------------------------------------------------------------------
`define MCF_LAY_SDRAM16    2'h3
`define MCF_LAY_SDRAM8     2'h2
`define MCF_LAY_DRAM32     2'h1
`define MCF_LAY_DRAM16     2'h0
`define MCF_W8             2'h0
`define MCF_W16            2'h1
`define MCF_W32            2'h2

// ----------------------------------------------------------------------
// Column map codes above this are reserved; page burst length
// ----------------------------------------------------------------------
`define MCF_COL_LAST       4'h9
`define MCF_BURST_NEXT     2'h3

// ----------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------
`define MCF_RESP_OKAY      2'h0
`define MCF_RESP_SLVERR    2'h2

`endif
